// >>> rtl/fmc_pkg.sv
// Package for the flag and MCU control operation unit
package fmc_pkg;

   // Status flags register bit positions
   localparam int FLAG_C_POS = 0;
   localparam int FLAG_Z_POS = 1;
   localparam int FLAG_N_POS = 2;
   localparam int FLAG_V_POS = 3;
   localparam int FLAG_S_POS = 4;
   localparam int FLAG_H_POS = 5;
   localparam int FLAG_T_POS = 6;
   localparam int FLAG_I_POS = 7;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   // Wishbone register byte addresses
   localparam logic [3:0] ADDR_FLAGS  = 4'h0;
   localparam logic [3:0] ADDR_OP     = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_COUNT  = 4'hC;

   // Operation codes written to the operation register
   localparam logic [3:0] OP_NOP        = 4'h0;
   localparam logic [3:0] OP_SET_V      = 4'h1;
   localparam logic [3:0] OP_CLR_V      = 4'h2;
   localparam logic [3:0] OP_SET_T      = 4'h3;
   localparam logic [3:0] OP_CLR_T      = 4'h4;
   localparam logic [3:0] OP_SET_H      = 4'h5;
   localparam logic [3:0] OP_CLR_H      = 4'h6;
   localparam logic [3:0] OP_SLEEP      = 4'h7;
   localparam logic [3:0] OP_WDOG       = 4'h8;
   localparam logic [3:0] OP_BREAK      = 4'h9;

   // Status register bit positions
   localparam int ST_ILLEGAL_POS = 0;
   localparam int ST_BREAK_POS   = 1;

   // Wishbone request bundle
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } fmc_wb_req_t;

   // Whole module state
   typedef struct packed {
      logic [7:0]  flags;
      logic        ack;
      logic [31:0] rdata;
      logic        sleep_req;
      logic        wdog_restart;
      logic        break_req;
      logic        illegal;
      logic        break_seen;
      logic [15:0] op_count;
   } fmc_state_t;

endpackage : fmc_pkg

// >>> rtl/fmc_core.sv
// Flag set/clear and MCU control operation unit with Wishbone slave
//
// Operation
// - Set overflow: V=1, one clock only
// - Clear overflow: V=0, one clock only
// - Set half carry: H=1, one clock
// - Clear half carry: H=0, one clock
// - Sleep and no-op: one clock, flags kept
// - Watchdog restart: one clock, pulse restart
// - Break only when debug enabled, no flags
//
// Our own choices: register access over Wishbone and the register addresses.
module fmc_core
   import fmc_pkg::*;
(
   input  wire logic        clk_sys_i,      // 40 MHz core clock
   input  wire logic        reset_i,        // Sync reset, active high
   input  wire logic        wb_cyc_i,       // Wishbone cycle
   input  wire logic        wb_stb_i,       // Wishbone strobe
   input  wire logic        wb_we_i,        // Wishbone write enable
   input  wire logic [3:0]  wb_adr_i,       // Wishbone byte address
   input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects
   input  wire logic [31:0] wb_dat_i,       // Wishbone write data
   input  wire logic        debug_enable_i, // On-chip debug present
   output logic [31:0]      wb_dat_o,       // Wishbone read data
   output logic             wb_ack_o,       // Wishbone acknowledge
   output logic [7:0]       flags_o,        // Status flags register
   output logic             sleep_req_o,    // Sleep hand-off pulse
   output logic             wdog_restart_o, // Watchdog restart pulse
   output logic             break_req_o     // Debug break pulse
);

   fmc_state_t  state_reg;
   fmc_state_t  state_next;
   fmc_wb_req_t req;
   logic        access;
   logic        wr_op;
   logic [3:0]  op_code;

   // Write strobe for one register; only byte lane 0 carries fields
   function automatic logic wr_hit(input logic        acc,
                                   input fmc_wb_req_t r,
                                   input logic [3:0]  a);
      wr_hit = acc && r.we && r.sel[0] && (r.adr == a);
   endfunction

   // Bundle the bus request
   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                  adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

   // New access only when no ack is outstanding, so one ack per request
   assign access  = req.cyc && req.stb && !state_reg.ack;
   assign wr_op   = wr_hit(access, req, ADDR_OP);
   assign op_code = req.dat[3:0];

   // Byte-lane merge for the flags register write
   function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic       en);
      merge_byte = en ? new_v : old_v;
   endfunction

   // Next-state logic
   always_comb begin
      state_next              = state_reg;
      state_next.ack          = access;
      // Pulses drop by default, so each lasts exactly one cycle
      state_next.sleep_req    = 1'b0;
      state_next.wdog_restart = 1'b0;
      state_next.break_req    = 1'b0;
      if (access && req.we && (req.adr == ADDR_FLAGS)) begin
         state_next.flags = merge_byte(state_reg.flags, req.dat[7:0],
                                       req.sel[0]);
      end
      // Status write-one-to-clear
      if (wr_hit(access, req, ADDR_STATUS)) begin
         if (req.dat[ST_ILLEGAL_POS]) begin
            state_next.illegal = 1'b0;
         end
         if (req.dat[ST_BREAK_POS]) begin
            state_next.break_seen = 1'b0;
         end
      end
      // Execute one operation per write; each touches at most one flag
      if (wr_op) begin
         state_next.op_count = state_reg.op_count + 16'h0001;
         case (op_code)
            OP_NOP: begin
               state_next.flags = state_reg.flags;
            end
            OP_SET_V: state_next.flags[FLAG_V_POS] = 1'b1;
            OP_CLR_V: state_next.flags[FLAG_V_POS] = 1'b0;
            OP_SET_T: state_next.flags[FLAG_T_POS] = 1'b1;
            OP_CLR_T: state_next.flags[FLAG_T_POS] = 1'b0;
            OP_SET_H: state_next.flags[FLAG_H_POS] = 1'b1;
            OP_CLR_H: state_next.flags[FLAG_H_POS] = 1'b0;
            OP_SLEEP: state_next.sleep_req = 1'b1;
            OP_WDOG:  state_next.wdog_restart = 1'b1;
            OP_BREAK: begin
               // Without debug support break is treated as illegal
               if (debug_enable_i) begin
                  state_next.break_req  = 1'b1;
                  state_next.break_seen = 1'b1;
               end else begin
                  state_next.illegal = 1'b1;
               end
            end
            default: state_next.illegal = 1'b1;
         endcase
      end
      // Read mux; unmapped addresses read zero
      state_next.rdata = 32'h0000_0000;
      if (access && !req.we) begin
         case (req.adr)
            ADDR_FLAGS:  state_next.rdata = {24'h00_0000, state_reg.flags};
            ADDR_STATUS: state_next.rdata = {30'h0000_0000,
                                             state_reg.break_seen,
                                             state_reg.illegal};
            ADDR_COUNT:  state_next.rdata = {16'h0000, state_reg.op_count};
            default:     state_next.rdata = 32'h0000_0000;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_reg <= '{flags: FLAGS_RESET, ack: 1'b0,
                        rdata: 32'h0000_0000, sleep_req: 1'b0,
                        wdog_restart: 1'b0, break_req: 1'b0,
                        illegal: 1'b0, break_seen: 1'b0,
                        op_count: 16'h0000};
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flops; pulses stand in the ack cycle
   assign wb_dat_o       = state_reg.rdata;
   assign wb_ack_o       = state_reg.ack;
   assign flags_o        = state_reg.flags;
   assign sleep_req_o    = state_reg.sleep_req;
   assign wdog_restart_o = state_reg.wdog_restart;
   assign break_req_o    = state_reg.break_req;

   // Mask of flags that an op must leave unchanged
   function automatic logic [7:0] keep_mask(input int pos);
      keep_mask = ~(8'h01 << pos);
   endfunction

   // Checks sample one edge after an op write is taken: that is where
   // software sees the result, in the same cycle as the ack. Each
   // single-flag op is also checked against the other seven flags,
   // since one shared next-state copy makes a stray write easy.

   // Set overflow: V high, every other flag held
   a_set_overflow: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_op && op_code == OP_SET_V
      |=> flags_o[FLAG_V_POS] &&
          (flags_o & keep_mask(FLAG_V_POS)) ==
          ($past(flags_o) & keep_mask(FLAG_V_POS)))
      else $error("set overflow wrong");

   // Clear overflow: V low, every other flag held
   a_clear_overflow: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_op && op_code == OP_CLR_V
      |=> !flags_o[FLAG_V_POS] &&
          (flags_o & keep_mask(FLAG_V_POS)) ==
          ($past(flags_o) & keep_mask(FLAG_V_POS)))
      else $error("clear overflow wrong");

   // Set half carry: H high, every other flag held
   a_set_half: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_op && op_code == OP_SET_H
      |=> flags_o[FLAG_H_POS] &&
          (flags_o & keep_mask(FLAG_H_POS)) ==
          ($past(flags_o) & keep_mask(FLAG_H_POS)))
      else $error("set half carry wrong");

   // Clear half carry: H low, every other flag held
   a_clear_half: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_op && op_code == OP_CLR_H
      |=> !flags_o[FLAG_H_POS] &&
          (flags_o & keep_mask(FLAG_H_POS)) ==
          ($past(flags_o) & keep_mask(FLAG_H_POS)))
      else $error("clear half carry wrong");

   // Transfer bit follows the op, every other flag held
   a_t_flag: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_op && (op_code == OP_SET_T || op_code == OP_CLR_T)
      |=> flags_o[FLAG_T_POS] == ($past(op_code) == OP_SET_T) &&
          (flags_o & keep_mask(FLAG_T_POS)) ==
          ($past(flags_o) & keep_mask(FLAG_T_POS)))
      else $error("T flag op wrong");

   // No-op: flags hold, no pulse leaves the unit
   a_nop_quiet: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_op && op_code == OP_NOP
      |=> $stable(flags_o) && !sleep_req_o && !wdog_restart_o &&
          !break_req_o)
      else $error("no-op changed state");

   // Sleep hand-off is a single pulse; flags untouched
   a_sleep_pulse: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_op && op_code == OP_SLEEP
      |=> sleep_req_o && $stable(flags_o) ##1 !sleep_req_o)
      else $error("sleep pulse wrong");

   // Watchdog op gives exactly one restart pulse; flags untouched
   a_wdog_issue: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_op && op_code == OP_WDOG
      |=> wdog_restart_o && $stable(flags_o) ##1 !wdog_restart_o)
      else $error("watchdog restart missing");

   // A restart pulse never appears without its op
   a_wdog_pulse: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wdog_restart_o
      |-> $past(wr_op) && $past(op_code) == OP_WDOG && $stable(flags_o))
      else $error("watchdog restart wrong");

   // Break only leaves the unit when debug support was present
   a_break_gate: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      break_req_o
      |-> $past(debug_enable_i) && $past(wr_op) &&
          $past(op_code) == OP_BREAK && $stable(flags_o))
      else $error("break without debug");

   // Without debug support the break is refused: no pulse, flags
   // kept, and the illegal status bit tells software why
   a_break_blocked: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_op && op_code == OP_BREAK && !debug_enable_i
      |=> !break_req_o && $stable(flags_o) && state_reg.illegal)
      else $error("break passed without debug");

   // Codes above break are refused the same way; a future op code
   // written by newer software must not disturb the flags
   a_illegal_code: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_op && op_code > OP_BREAK
      |=> state_reg.illegal && $stable(flags_o) &&
          !sleep_req_o && !wdog_restart_o && !break_req_o)
      else $error("unknown op code accepted");

   // Op counter steps once per op write and wraps; it is how software
   // confirms that a write reached the decoder
   a_count_step: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_op
      |=> state_reg.op_count == $past(state_reg.op_count) + 16'h0001)
      else $error("op count step wrong");

   // Flags write with byte lane 0 off is dropped
   a_flags_lane: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      access && wb_we_i && wb_adr_i == ADDR_FLAGS && !wb_sel_i[0]
      |=> $stable(flags_o))
      else $error("flags write without lane");

   // Write one to clear the illegal flag; no op can coincide with it
   a_status_clear: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_hit(access, req, ADDR_STATUS) && req.dat[ST_ILLEGAL_POS]
      |=> !state_reg.illegal)
      else $error("illegal flag not cleared");

   // Bus answers one edge after a request is taken; a master that
   // counts on this fixed latency still works if it waits for ack
   a_ack_answer: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      access |=> wb_ack_o)
      else $error("ack latency wrong");

   // One ack per request, never a held ack
   a_ack_single: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   // Read data is zero outside the ack cycle, so a shared read bus
   // can be OR-ed without a separate select
   a_read_idle: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");

   // Pulses only come with the ack of the op write that made them;
   // the sleep, watchdog and debug units rely on that one cycle
   a_pulse_ack: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      sleep_req_o || wdog_restart_o || break_req_o
      |-> wb_ack_o)
      else $error("pulse without ack");

   // Main scenarios; back-to-back is the fastest that a classic
   // master reaches, two idle cycles between requests
   c_sleep: cover property (@(posedge clk_sys_i) sleep_req_o);
   c_wdog: cover property (@(posedge clk_sys_i) wdog_restart_o);
   c_break: cover property (@(posedge clk_sys_i) break_req_o);
   c_back2back: cover property (@(posedge clk_sys_i) wr_op ##3 wr_op);

endmodule // fmc_core

// >>> verif/flag_and_mcu_control_ops_tb.sv
// Self-checking bench for the flag and MCU control operation unit
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
   err_count++; $display("unexpected at %0t: got %h exp %h", \
   $time, got, exp); end end
module flag_and_mcu_control_ops_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fmc_pkg::*;

   typedef struct packed {
      logic [7:0] init;
      logic [3:0] op;
      logic       dbg;
      logic [7:0] flags;
      logic [2:0] pls;
   } fmc_row_t;

   logic        clk_sys_i = 1'b0;
   logic        reset_i   = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, dbg = 1'b0;
   logic [3:0]  adr = 4'h0, sel = 4'h1;
   logic [31:0] wdat = 32'h0, rd;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o, sleep_req_o, wdog_restart_o, break_req_o;
   logic [7:0]  flags_o, flg;
   logic [2:0]  pls;
   int          err_count = 0, n_checks = 0, cycles = 0;
   fmc_row_t    rows [12];

   fmc_core u_dut (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .debug_enable_i(dbg), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .flags_o(flags_o), .sleep_req_o(sleep_req_o),
      .wdog_restart_o(wdog_restart_o), .break_req_o(break_req_o));

   // 40 MHz core clock
   initial begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   // Hang guard, generous against a run of about 150 cycles
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Classic cycle; answer, flags and pulses taken at the ack edge only;
   // the wait has no limit of its own, the hang guard ends a lost ack
   task automatic wb(input logic        w,
                     input logic [3:0]  a,
                     input logic [31:0] d,
                     input logic [3:0]  s = 4'h1);
      @(posedge clk_sys_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
      do begin
         @(posedge clk_sys_i);
      end while (wb_ack_o !== 1'b1);
      rd  = wb_dat_o;
      flg = flags_o;
      pls = {sleep_req_o, wdog_restart_o, break_req_o};
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask

   initial begin
      // Start flags, op, debug present, flags and pulses expected
      rows = '{'{8'hF7, OP_SET_V, 1'b0, 8'hFF, 3'b000},
               '{8'h00, OP_SET_V, 1'b0, 8'h08, 3'b000},
               '{8'hFF, OP_CLR_V, 1'b0, 8'hF7, 3'b000},
               '{8'hDF, OP_SET_H, 1'b0, 8'hFF, 3'b000},
               '{8'hFF, OP_CLR_H, 1'b0, 8'hDF, 3'b000},
               '{8'hBF, OP_SET_T, 1'b0, 8'hFF, 3'b000},
               '{8'hFF, OP_CLR_T, 1'b0, 8'hBF, 3'b000},
               '{8'hA5, OP_NOP,   1'b0, 8'hA5, 3'b000},
               '{8'h5A, OP_SLEEP, 1'b0, 8'h5A, 3'b100},
               '{8'hC3, OP_WDOG,  1'b0, 8'hC3, 3'b010},
               '{8'h3C, OP_BREAK, 1'b1, 8'h3C, 3'b001},
               '{8'h66, OP_BREAK, 1'b0, 8'h66, 3'b000}};
      repeat (16) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      `CHK(flags_o, FLAGS_RESET)
      foreach (rows[i]) begin
         dbg <= rows[i].dbg;
         wb(1'b1, ADDR_FLAGS, {24'h0, rows[i].init});
         wb(1'b1, ADDR_OP, {28'h0, rows[i].op});
         `CHK(flg, rows[i].flags)
         `CHK(pls, rows[i].pls)
         @(posedge clk_sys_i);
         `CHK({sleep_req_o, wdog_restart_o, break_req_o}, 3'b000)
         `CHK(flags_o, rows[i].flags)
      end
      // Break without debug present must flag an illegal request
      wb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd[ST_ILLEGAL_POS], 1'b1)
      `CHK(rd[ST_BREAK_POS], 1'b1)
      wb(1'b1, ADDR_STATUS, 32'h1);
      wb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd, 32'h00000002)
      wb(1'b0, ADDR_COUNT, 32'h0);
      `CHK(rd, 32'h0000000C)
      wb(1'b0, ADDR_FLAGS, 32'h0);
      `CHK(rd, 32'h00000066)
      // Flags write with byte lane 0 off leaves the flags alone
      wb(1'b1, ADDR_FLAGS, 32'h000000FF, 4'hE);
      wb(1'b0, ADDR_FLAGS, 32'h0);
      `CHK(rd, 32'h00000066)
      // Unmapped offset reads zero
      wb(1'b0, 4'h2, 32'h0);
      `CHK(rd, 32'h00000000)
      // Unknown op code: flags held, no pulse, illegal raised
      wb(1'b1, ADDR_OP, {28'h0, 4'hF});
      `CHK(flg, 8'h66)
      `CHK(pls, 3'b000)
      wb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd, 32'h00000003)
      // Back-to-back ops: each edit is confined to its own bit
      wb(1'b1, ADDR_OP, {28'h0, OP_SET_V});
      wb(1'b1, ADDR_OP, {28'h0, OP_SET_H});
      `CHK(flg, 8'h6E)
      // Reset mid-run returns flags to the reset value
      @(posedge clk_sys_i);
      reset_i <= 1'b1;
      @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      `CHK(flags_o, FLAGS_RESET)
      wb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd, 32'h00000000)
      wb(1'b0, ADDR_COUNT, 32'h0);
      `CHK(rd, 32'h00000000)
      finish_test();
   end
endmodule // flag_and_mcu_control_ops_tb
